// ---- src/power_down_mode_control.sv ----
// Power-down mode controller: standby control register, sleep/standby sequencing,
// module clock gating, state pins and wake handling.
// Assumes the core, interrupt logic and watchdog run on clk_i; level inputs and
// the nonmaskable input arrive from pins.
//
// Notes on behaviour
// - Control register read/write, zero on power-on
// - Bits 6..3 read zero, write zero
// - Select bit 0: sleep on request
// - Select bit 1: standby on request
// - Timer gate stops timer, clears start
// - Calendar gate stops interface, blocks access
// - Serial gate stops clock, resets pins
// - Gated timer pins hold previous levels
// - Sleep halts core, peripherals, bus clock run
// - Sleep pins high-low, refresh low-low
// - Sleep wakes on any interrupt, reset
// - Interrupt wake loads event code
// - Standby stops core, clocks, peripherals, bus
// - Standby entry clears timer start register
// - Standby pins low-high once clocks stop
// - Standby wake waits settling, then normal
// - No interval wake; level above mask
// - Block bit ignored; calendar-clocked peripherals only
// - Gating released by clearing or reset
// - Pin codes: reset, sleep, standby, normal
// - Manual reset keeps control register
`timescale 1ns/100ps

module power_down_mode_control
    import power_down_pkg::*;
#(
    parameter int TIMER_PIN_W = 3
) (
    // Clock and resets
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       manual_reset_i,
    // Register bus
    input  wire power_down_pkg::wb_req_type wb_req_i,
    output      power_down_pkg::wb_rsp_type wb_rsp_o,
    // Processor core
    input  wire logic                       sleep_req_i,
    input  wire logic                       refresh_active_i,
    input  wire logic [LEVEL_W-1:0]         interrupt_mask_level_i,
    output      logic                       wake_o,
    output      logic [EVENT_W-1:0]         interrupt_event_o,
    // Interrupt sources
    input  wire logic                       nmi_pin_i,
    input  wire logic [LEVEL_W-1:0]         external_level_inputs_i,
    input  wire logic                       periph_irq_i,
    input  wire logic                       periph_calendar_i,
    input  wire logic [EVENT_W-1:0]         periph_code_i,
    // Watchdog settling
    input  wire logic                       settle_done_i,
    output      logic                       settle_start_o,
    // Clock enables and module control
    output      power_down_pkg::clk_en_type clk_en_o,
    output      logic                       timer_start_clear_o,
    output      logic                       calendar_access_block_o,
    output      logic                       serial_pins_reset_o,
    input  wire logic [TIMER_PIN_W-1:0]     timer_pin_i,
    output      logic [TIMER_PIN_W-1:0]     timer_pin_o,
    // State pins
    output      logic                       upper_state_pin_o,
    output      logic                       lower_state_pin_o
);

    import power_down_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    mode_type             mode;
    logic [CONTROL_W-1:0] standby_control;
    logic                 nmi_meta;
    logic                 nmi_sync;
    logic [LEVEL_W-1:0]   level_meta;
    logic [LEVEL_W-1:0]   level_sync;
    logic                 level_ok;
    logic                 sleep_wake;
    logic                 standby_wake;
    logic [EVENT_W-1:0]   next_event;
    logic                 bus_req;
    logic                 hit_control;
    logic                 hit_status;
    logic                 control_write;
    logic                 gate_active;
    logic                 any_reset;
    logic                 timer_gated;
    logic [WB_DATA_W-1:0] read_word;

    function automatic logic [EVENT_W-1:0] level_event(input logic [LEVEL_W-1:0] lvl);
        level_event = LEVEL_EVENT_BASE
                    | EVENT_W'({lvl, LEVEL_SHIFT'(0)});
    endfunction

    function automatic logic [WB_DATA_W-1:0] widen(input logic [CONTROL_W-1:0] v);
        widen = WB_DATA_W'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_meta   <= 1'b0;
            nmi_sync   <= 1'b0;
            level_meta <= '0;
            level_sync <= '0;
        end else begin
            nmi_meta   <= nmi_pin_i;
            nmi_sync   <= nmi_meta;
            level_meta <= external_level_inputs_i;
            level_sync <= level_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake qualification; block bit deliberately not consulted
    assign any_reset    = rst_i | manual_reset_i;
    assign level_ok     = level_sync > interrupt_mask_level_i;
    assign sleep_wake   = nmi_sync | level_ok | periph_irq_i;
    assign standby_wake = nmi_sync | level_ok
                        | (periph_irq_i & periph_calendar_i);

    always_comb begin
        if (nmi_sync) begin
            next_event = NMI_EVENT_CODE;
        end else if (level_ok) begin
            next_event = level_event(level_sync);
        end else begin
            next_event = periph_code_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            mode <= mode_run;
        end else begin
            unique case (mode)
                mode_run: begin
                    if (sleep_req_i) begin
                        mode <= standby_control[STANDBY_SELECT_POS]
                              ? mode_standby
                              : mode_sleep;
                    end
                end
                mode_sleep: begin
                    if (sleep_wake) begin
                        mode <= mode_run;
                    end
                end
                mode_standby: begin
                    if (standby_wake) begin
                        mode <= mode_settle;
                    end
                end
                mode_settle: begin
                    if (settle_done_i) begin
                        mode <= mode_run;
                    end
                end
            endcase
        end
    end

    // Wake pulse, settling start and event code
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            wake_o            <= 1'b0;
            settle_start_o    <= 1'b0;
            interrupt_event_o <= '0;
        end else begin
            wake_o         <= (mode == mode_sleep && sleep_wake)
                            | (mode == mode_settle && settle_done_i);
            settle_start_o <= mode == mode_standby && standby_wake;
            if ((mode == mode_sleep && sleep_wake)
                || (mode == mode_standby && standby_wake)) begin
                interrupt_event_o <= next_event;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State pins
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            {upper_state_pin_o, lower_state_pin_o} <= PINS_RESET;
        end else begin
            unique case (mode)
                mode_sleep: begin
                    {upper_state_pin_o, lower_state_pin_o} <= refresh_active_i
                        ? PINS_NORMAL : PINS_SLEEP;
                end
                mode_standby, mode_settle: begin
                    {upper_state_pin_o, lower_state_pin_o} <= PINS_STANDBY;
                end
                mode_run: begin
                    {upper_state_pin_o, lower_state_pin_o} <= PINS_NORMAL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock enables and module gating
    assign gate_active = ~manual_reset_i;
    assign timer_gated = standby_control[TIMER_GATE_POS] & gate_active;

    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            clk_en_o                <= '1;
            timer_start_clear_o     <= 1'b0;
            calendar_access_block_o <= 1'b0;
            serial_pins_reset_o     <= 1'b0;
        end else begin
            clk_en_o.core      <= mode == mode_run;
            clk_en_o.periph    <= mode == mode_run || mode == mode_sleep;
            clk_en_o.bus_clock <= mode == mode_run || mode == mode_sleep;
            clk_en_o.timer     <= (mode == mode_run || mode == mode_sleep)
                                & ~timer_gated;
            clk_en_o.calendar  <= (mode == mode_run || mode == mode_sleep)
                                & ~(standby_control[CALENDAR_GATE_POS] & gate_active);
            clk_en_o.serial    <= (mode == mode_run || mode == mode_sleep)
                                & ~(standby_control[SERIAL_GATE_POS] & gate_active);
            timer_start_clear_o <= timer_gated
                                 | mode == mode_standby | mode == mode_settle;
            calendar_access_block_o <= standby_control[CALENDAR_GATE_POS]
                                     & gate_active;
            serial_pins_reset_o <= standby_control[SERIAL_GATE_POS]
                                 & gate_active;
        end
    end

    // Timer pins frozen while gated
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_pin_o <= '0;
        end else if (!timer_gated) begin
            timer_pin_o <= timer_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign bus_req       = wb_req_i.cyc & wb_req_i.stb;
    assign hit_control   = wb_req_i.adr == CONTROL_OFFSET;
    assign hit_status    = wb_req_i.adr == STATUS_OFFSET;
    assign control_write = bus_req & wb_req_i.we & wb_rsp_o.ack & hit_control
                         & wb_req_i.sel[0] & ~manual_reset_i;

    always_comb begin
        read_word = '0;
        if (hit_control) begin
            read_word = widen(standby_control);
        end else if (hit_status) begin
            read_word[STATUS_PINS_LO+1:STATUS_PINS_LO] =
                {upper_state_pin_o, lower_state_pin_o};
            read_word[STATUS_HALT_POS] = mode != mode_run;
            read_word[STATUS_STANDBY_SELECT_BIT_POS] = mode == mode_standby;
            read_word[STATUS_WAIT_POS] = mode == mode_settle;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_rsp_o <= '0;
        end else begin
            wb_rsp_o.ack <= bus_req & ~wb_rsp_o.ack;
            if (bus_req && !wb_rsp_o.ack) begin
                wb_rsp_o.dat <= read_word;
            end
        end
    end

    // Standby control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_control <= CONTROL_RESET;
        end else if (control_write) begin
            standby_control <= wb_req_i.dat[CONTROL_W-1:0]
                             & CONTROL_WRITABLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reserved_bits_zero: assert property (
        standby_control[RESERVED_HI:RESERVED_LO] == '0)
        else $error("reserved control bits not zero");

    a_sleep_entry: assert property (
        (mode == mode_run && sleep_req_i && !manual_reset_i
         && !standby_control[STANDBY_SELECT_POS])
        |=> mode == mode_sleep ##1 !clk_en_o.core && clk_en_o.bus_clock)
        else $error("sleep request did not enter sleep");

    a_standby_entry: assert property (
        (mode == mode_run && sleep_req_i && !manual_reset_i
         && standby_control[STANDBY_SELECT_POS])
        |=> mode == mode_standby ##1 !clk_en_o.bus_clock && timer_start_clear_o)
        else $error("sleep request did not enter standby");

    a_sleep_pin_code: assert property (
        (mode == mode_sleep && !manual_reset_i)
        |=> {upper_state_pin_o, lower_state_pin_o}
            == ($past(refresh_active_i) ? PINS_NORMAL : PINS_SLEEP))
        else $error("sleep state pins wrong");

    a_standby_pin_code: assert property (
        (mode == mode_standby && !manual_reset_i)
        |=> {upper_state_pin_o, lower_state_pin_o} == PINS_STANDBY)
        else $error("standby state pins wrong");

    a_settle_wait: assert property (
        (mode == mode_settle && !settle_done_i && !manual_reset_i)
        |=> mode == mode_settle && !wake_o)
        else $error("standby left before settling");

    a_wake_code: assert property (
        (mode == mode_sleep && sleep_wake && !manual_reset_i)
        |=> wake_o && interrupt_event_o == $past(next_event))
        else $error("sleep wake code missing");

    a_wake_filter: assert property (
        (mode == mode_standby && !nmi_sync && !manual_reset_i
         && level_sync <= interrupt_mask_level_i
         && !(periph_irq_i && periph_calendar_i))
        |=> mode == mode_standby)
        else $error("standby left without wake source");

    a_timer_gate_off: assert property (
        (timer_gated && !manual_reset_i) |=> !clk_en_o.timer)
        else $error("timer clock runs while gated");

    a_timer_pin_hold: assert property (
        (timer_gated && $past(timer_gated)) |-> $stable(timer_pin_o))
        else $error("gated timer pins changed");

    a_manual_keeps: assert property (
        manual_reset_i |=> $stable(standby_control)
                           && {upper_state_pin_o, lower_state_pin_o} == PINS_RESET)
        else $error("manual reset altered control");

    a_calendar_block: assert property (
        (standby_control[CALENDAR_GATE_POS] && !manual_reset_i)
        |=> calendar_access_block_o && !clk_en_o.calendar)
        else $error("calendar gate not applied");

    a_serial_reset: assert property (
        (standby_control[SERIAL_GATE_POS] && !manual_reset_i)
        |=> serial_pins_reset_o && !clk_en_o.serial)
        else $error("serial gate not applied");

    a_sleep_clocks: assert property (
        (mode == mode_sleep && !manual_reset_i)
        |=> !clk_en_o.core && clk_en_o.periph && clk_en_o.bus_clock)
        else $error("sleep clock enables wrong");

    a_standby_clocks: assert property (
        (mode == mode_standby && !manual_reset_i)
        |=> !clk_en_o.core && !clk_en_o.periph && !clk_en_o.bus_clock)
        else $error("standby clock enables wrong");

    a_settle_start: assert property (
        (mode == mode_standby && standby_wake && !manual_reset_i)
        |=> settle_start_o && mode == mode_settle)
        else $error("standby wake did not start settling");

    a_gate_release: assert property (
        manual_reset_i
        |=> clk_en_o == '1 && !timer_start_clear_o
            && !calendar_access_block_o && !serial_pins_reset_o)
        else $error("manual reset did not release gating");

endmodule // power_down_mode_control

// ---- src/power_down_pkg.sv ----
// Constants, field layout and carrier types for the power-down mode controller.
// Assumes a 32-bit classic Wishbone register bus and one 250 MHz clock.
package power_down_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int WB_ADDR_W = 32;
    localparam int WB_DATA_W = 32;
    localparam int WB_SEL_W  = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [WB_ADDR_W-1:0] CONTROL_OFFSET = 32'h0000_0000;
    localparam logic [WB_ADDR_W-1:0] STATUS_OFFSET  = 32'h0000_0004;

    // Standby control fields
    localparam int CONTROL_W          = 8;
    localparam int STANDBY_SELECT_POS = 7;
    localparam int RESERVED_HI        = 6;
    localparam int RESERVED_LO        = 3;
    localparam int TIMER_GATE_POS     = 2;
    localparam int CALENDAR_GATE_POS  = 1;
    localparam int SERIAL_GATE_POS    = 0;
    localparam logic [CONTROL_W-1:0] CONTROL_RESET    = 8'h00;
    localparam logic [CONTROL_W-1:0] CONTROL_WRITABLE = 8'h87;

    // Status fields
    localparam int STATUS_PINS_LO  = 0;
    localparam int STATUS_HALT_POS = 2;
    localparam int STATUS_STANDBY_SELECT_BIT_POS = 3;
    localparam int STATUS_WAIT_POS = 4;

    ////////////////////////////////////////////////////////////////////////////
    // State pin codes {upper, lower}
    localparam logic [1:0] PINS_RESET   = 2'h3;
    localparam logic [1:0] PINS_SLEEP   = 2'h2;
    localparam logic [1:0] PINS_STANDBY = 2'h1;
    localparam logic [1:0] PINS_NORMAL  = 2'h0;

    // Interrupt event codes (values arbitrary)
    localparam int LEVEL_W     = 4;
    localparam int EVENT_W     = 12;
    localparam int LEVEL_SHIFT = 5;
    localparam logic [EVENT_W-1:0] NMI_EVENT_CODE   = 12'h1C0;
    localparam logic [EVENT_W-1:0] LEVEL_EVENT_BASE = 12'h200;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        mode_run,
        mode_sleep,
        mode_standby,
        mode_settle
    } mode_type;

    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [WB_ADDR_W-1:0] adr;
        logic [WB_SEL_W-1:0]  sel;
        logic [WB_DATA_W-1:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic                 ack;
        logic [WB_DATA_W-1:0] dat;
    } wb_rsp_type;

    typedef struct packed {
        logic core;
        logic periph;
        logic bus_clock;
        logic timer;
        logic calendar;
        logic serial;
    } clk_en_type;

endpackage

// ---- tb/settle_model.sv ----
// Watchdog settling partner: answers a start pulse with a one-cycle done pulse.
// Assumes the controller's clock and power-on reset.
`timescale 1ns/100ps

module settle_model #(
    parameter int SETTLE = 8
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Settling handshake
    input  wire logic settle_start_i,
    output      logic settle_done_o
);
    int count;

    // Count loaded from SETTLE on each start pulse
    always_ff @(posedge clk_i) begin
        settle_done_o <= 1'b0;
        if (rst_i) begin
            count <= 0;
        end else if (settle_start_i) begin
            count <= SETTLE;
        end else if (count == 1) begin
            count         <= 0;
            settle_done_o <= 1'b1;
        end else if (count > 1) begin
            count <= count - 1;
        end
    end
endmodule // settle_model

// ---- tb/tb.sv ----
// Self-checking bench for the power-down mode controller.
// Assumes the settling partner model and a 250 MHz clock.
`timescale 1ns/100ps

module tb;
    import power_down_pkg::*;
    localparam int SETTLE = 8;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               manual_reset_i = 1'b0;
    wb_req_type         wb_req_i = '0;
    wb_rsp_type         wb_rsp_o;
    logic               sleep_req_i = 1'b0;
    logic               refresh_active_i = 1'b0;
    logic [LEVEL_W-1:0] mask = 4'h2;
    logic               wake_o;
    logic [EVENT_W-1:0] event_code;
    logic               nmi_pin_i = 1'b0;
    logic [LEVEL_W-1:0] level = 4'h0;
    logic               periph_irq_i = 1'b0;
    logic               periph_calendar_i = 1'b0;
    logic [EVENT_W-1:0] periph_code_i = 12'h3A0;
    logic               settle_done_i;
    logic               settle_start_o;
    clk_en_type         clk_en_o;
    wire  [2:0]         gate_out;
    logic [2:0]         timer_pin_i = 3'h5;
    logic [2:0]         timer_pin_o;
    wire  [1:0]         pins;
    int                 errors = 0;
    int                 n_compared = 0;
    int                 n;
    logic [31:0]        rd;

    always #2 clk_i = ~clk_i;

    power_down_mode_control dut (
        .clk_i(clk_i), .rst_i(rst_i), .manual_reset_i(manual_reset_i),
        .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .sleep_req_i(sleep_req_i),
        .refresh_active_i(refresh_active_i), .interrupt_mask_level_i(mask),
        .wake_o(wake_o), .interrupt_event_o(event_code), .nmi_pin_i(nmi_pin_i),
        .external_level_inputs_i(level), .periph_irq_i(periph_irq_i),
        .periph_calendar_i(periph_calendar_i), .periph_code_i(periph_code_i),
        .settle_done_i(settle_done_i), .settle_start_o(settle_start_o),
        .clk_en_o(clk_en_o), .timer_start_clear_o(gate_out[2]),
        .calendar_access_block_o(gate_out[1]), .serial_pins_reset_o(gate_out[0]),
        .timer_pin_i(timer_pin_i), .timer_pin_o(timer_pin_o),
        .upper_state_pin_o(pins[1]), .lower_state_pin_o(pins[0])
    );

    settle_model #(.SETTLE(SETTLE)) settle (
        .clk_i(clk_i), .rst_i(rst_i), .settle_start_i(settle_start_o),
        .settle_done_o(settle_done_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // Classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [31:0] adr, input logic [7:0] wd);
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
        do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
        rd = wb_rsp_o.dat;
        wb_req_i <= '0;
    endtask

    task automatic enter(input logic [7:0] ctl);
        wb(1'b1, CONTROL_OFFSET, ctl);
        @(posedge clk_i);
        sleep_req_i <= 1'b1;
        @(posedge clk_i);
        sleep_req_i <= 1'b0;
        tick(2);
    endtask

    task automatic wait_wake();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wake_o !== 1'b1 && n < 60);
        check(wake_o, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        check(pins, PINS_NORMAL);
        wb(1'b0, CONTROL_OFFSET, 8'h00);
        check(rd, 32'h0000_0000);
        wb(1'b1, CONTROL_OFFSET, 8'hFF);
        wb(1'b0, CONTROL_OFFSET, 8'h00);
        check(rd, 32'h0000_0087);
        wb(1'b0, 32'h0000_0040, 8'h00);
        check(rd, 32'h0000_0000);
        $display("registers done");
    endtask

    task automatic t_gate();
        tick(2);
        check(clk_en_o, 6'h38);
        check(gate_out, 3'h7);
        timer_pin_i <= 3'h2;
        tick(3);
        check(timer_pin_o, 3'h5);
        wb(1'b1, CONTROL_OFFSET, 8'h00);
        tick(3);
        check(clk_en_o, 6'h3F);
        check(gate_out, 3'h0);
        check(timer_pin_o, 3'h2);
        $display("gating done");
    endtask

    task automatic t_sleep();
        enter(8'h00);
        check(pins, PINS_SLEEP);
        check(clk_en_o, 6'h1F);
        refresh_active_i <= 1'b1;
        tick(3);
        check(pins, PINS_NORMAL);
        refresh_active_i <= 1'b0;
        level <= 4'h2;
        tick(8);
        check(pins, PINS_SLEEP);
        level <= 4'h3;
        wait_wake();
        check(event_code, LEVEL_EVENT_BASE | (12'h3 << LEVEL_SHIFT));
        level <= 4'h0;
        tick(1);
        check(pins, PINS_NORMAL);
        enter(8'h00);
        nmi_pin_i <= 1'b1;
        wait_wake();
        check(event_code, NMI_EVENT_CODE);
        nmi_pin_i <= 1'b0;
        $display("sleep done");
    endtask

    task automatic t_standby();
        enter(8'h80);
        check(pins, PINS_STANDBY);
        check(clk_en_o, 6'h00);
        check(gate_out[2], 1'b1);
        wb(1'b0, STATUS_OFFSET, 8'h00);
        check(rd, 32'h0000_000D);
        periph_irq_i <= 1'b1;
        level <= 4'h2;
        tick(10);
        check(pins, PINS_STANDBY);
        periph_calendar_i <= 1'b1;
        wait_wake();
        check(n > SETTLE, 1'b1);
        check(event_code, periph_code_i);
        periph_irq_i <= 1'b0;
        periph_calendar_i <= 1'b0;
        level <= 4'h0;
        tick(1);
        check(pins, PINS_NORMAL);
        check(clk_en_o, 6'h3F);
        enter(8'h80);
        check(pins, PINS_STANDBY);
        nmi_pin_i <= 1'b1;
        wait_wake();
        check(n > SETTLE, 1'b1);
        check(event_code, NMI_EVENT_CODE);
        nmi_pin_i <= 1'b0;
        $display("standby done");
    endtask

    task automatic t_resets();
        wb(1'b1, CONTROL_OFFSET, 8'h81);
        manual_reset_i <= 1'b1;
        tick(3);
        check(pins, PINS_RESET);
        check(gate_out, 3'h0);
        check(clk_en_o, 6'h3F);
        manual_reset_i <= 1'b0;
        wb(1'b0, CONTROL_OFFSET, 8'h00);
        check(rd, 32'h0000_0081);
        enter(8'h81);
        rst_i <= 1'b1;
        tick(SETTLE);
        check(clk_en_o.bus_clock, 1'b1);
        check(pins, PINS_RESET);
        rst_i <= 1'b0;
        wb(1'b0, CONTROL_OFFSET, 8'h00);
        check(rd, 32'h0000_0000);
        $display("resets done");
    endtask

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        tick(6);
        rst_i <= 1'b0;
        tick(2);
        t_regs();
        wb(1'b1, CONTROL_OFFSET, 8'h07);
        t_gate();
        t_sleep();
        t_standby();
        t_resets();
        end_of_test();
    end

    initial begin
        #80000;
        errors++;
        end_of_test();
    end
endmodule // tb
